// ==== rtl/light_cfg_defs.vh ====
// Register offsets, field positions and reset values of the lighting configuration bank
`ifndef LIGHT_CFG_DEFS_VH
`define LIGHT_CFG_DEFS_VH

`define ADDR_CHARGE_PUMP_CONFIG   8'h26
`define ADDR_BANK_ENABLE          8'h27
`define ADDR_PATTERN_ENABLE       8'h28
`define ADDR_ZONE_SCALER_UPPER    8'h29
`define ADDR_ZONE_SCALER_MIDDLE   8'h2a
`define ADDR_ZONE_SCALER_ZERO     8'h2b
`define ADDR_BOOST_PWM_CONFIG     8'h2c
`define ADDR_SENSOR_RESISTOR      8'h30

`define RST_CHARGE_PUMP_CONFIG    8'h00
`define RST_BANK_ENABLE           8'h00
`define RST_PATTERN_ENABLE        8'h00
`define RST_ZONE_SCALER_UPPER     8'hff
`define RST_ZONE_SCALER_MIDDLE    8'hff
`define RST_ZONE_SCALER_ZERO      8'h00
`define RST_BOOST_PWM_CONFIG      8'h08
`define RST_SENSOR_RESISTOR       8'h00

`define MASK_CHARGE_PUMP_CONFIG   8'h07
`define MASK_BANK_ENABLE          8'h3f
`define MASK_PATTERN_ENABLE       8'hff
`define MASK_ZONE_SCALER_UPPER    8'hff
`define MASK_ZONE_SCALER_MIDDLE   8'hff
`define MASK_ZONE_SCALER_ZERO     8'h0f
`define MASK_BOOST_PWM_CONFIG     8'h0f
`define MASK_SENSOR_RESISTOR      8'h7f

`define CP_DISABLE_BIT            0
`define CP_GAIN_HI                2
`define CP_GAIN_LO                1
`define BP_FREQ_BIT               0
`define BP_OVL_HI                 2
`define BP_OVL_LO                 1
`define BP_POL_BIT                3

`define GAIN_AUTO                 2'h0
`define GAIN_ONE                  2'h1
`define GAIN_TWO                  2'h2

`endif

// ==== rtl/lighting_power_config_regs.v ====
// Configuration register bank of the lighting power device, with decoded controls
// Notes on behaviour
// - Pump gain bits 2:1: 0X auto, 10 1x, 11 2x
// - Pump disable bit 0 set turns pump off
// - Bank enable bits 5:0 enable banks A-F
// - Even pattern bits enable, odd bits enable scaling
// - Patterned map-two/three bank ignores zone targets
// - Zone scaler code N gives factor (N+1)/16
// - Zone 0 scaler bits 3:0, resets to 1/16
// - Boost register bit 3 sets PWM polarity, default high
// - Overvoltage code selects 16, 24, 32, 40 V
// - Frequency bit: 0 is 500 kHz, 1 is 1 MHz
// - Resistor code bits 6:0; zero means high impedance
// - Resistor code counts 10 uA steps at 2 V
`timescale 1ns/1ns
`include "light_cfg_defs.vh"

module lighting_power_config_regs (
	input  wire       clock_in,
	input  wire       resetn_in,
	input  wire       enable_in,
	input  wire       wr_strobe_in,
	input  wire       rd_strobe_in,
	input  wire [7:0] addr_in,
	input  wire [7:0] wdata_in,
	input  wire [5:0] bank_pattern_on_in,
	input  wire [5:0] bank_zone_map_in,
	output reg  [7:0] rdata_out,
	output reg        rvalid_out,
	output reg        addr_hit_out,
	output reg        pump_disable_out,
	output reg  [1:0] pump_gain_out,
	output reg  [5:0] bank_enable_out,
	output reg  [3:0] pattern_enable_out,
	output reg  [3:0] pattern_scaling_out,
	output reg  [19:0] zone_scaler_out,
	output reg        pwm_active_high_out,
	output reg  [1:0] overvoltage_limit_out,
	output reg        boost_fast_out,
	output reg  [6:0] sensor_gain_resistor_out,
	output reg        sensor_input_hiz_out,
	output reg  [5:0] bank_zone_target_use_out
);

////////////////////////////////////////////////////////////////////////////////
// Register slots, one per mapped address, kept in an indexed store

localparam       SLOT_COUNT       = 8;
localparam [2:0] SLOT_CHARGE_PUMP = 3'h0;
localparam [2:0] SLOT_BANK_ENABLE = 3'h1;
localparam [2:0] SLOT_PATTERN     = 3'h2;
localparam [2:0] SLOT_ZONE_UPPER  = 3'h3;
localparam [2:0] SLOT_ZONE_MIDDLE = 3'h4;
localparam [2:0] SLOT_ZONE_ZERO   = 3'h5;
localparam [2:0] SLOT_BOOST_PWM   = 3'h6;
localparam [2:0] SLOT_SENSOR      = 3'h7;

reg  [7:0] cfg_slot_reg [0:SLOT_COUNT-1];
reg  [2:0] slot_index;
reg        slot_hit;
reg  [7:0] rdata_next;
reg        hit_next;
reg  [1:0] gain_next;
wire       wr_take;
wire       rd_take;
wire       any_take;
wire [3:0] pattern_enable_next;
wire [3:0] pattern_scaling_next;
wire [7:0] charge_pump_config;
wire [7:0] bank_enable;
wire [7:0] pattern_enable_scaling;
wire [7:0] zone_scaler_upper;
wire [7:0] zone_scaler_middle;
wire [7:0] zone_scaler_zero;
wire [7:0] boost_pwm_config;
wire [7:0] sensor_resistor_select;
integer    k;
genvar     pg;

////////////////////////////////////////////////////////////////////////////////
// Per-slot reset values and writable-bit masks

function [7:0] slot_reset;
	input [2:0] sel;
	begin
		case (sel)
		SLOT_CHARGE_PUMP: slot_reset = `RST_CHARGE_PUMP_CONFIG;
		SLOT_BANK_ENABLE: slot_reset = `RST_BANK_ENABLE;
		SLOT_PATTERN:     slot_reset = `RST_PATTERN_ENABLE;
		SLOT_ZONE_UPPER:  slot_reset = `RST_ZONE_SCALER_UPPER;
		SLOT_ZONE_MIDDLE: slot_reset = `RST_ZONE_SCALER_MIDDLE;
		SLOT_ZONE_ZERO:   slot_reset = `RST_ZONE_SCALER_ZERO;
		SLOT_BOOST_PWM:   slot_reset = `RST_BOOST_PWM_CONFIG;
		SLOT_SENSOR:      slot_reset = `RST_SENSOR_RESISTOR;
		default:          slot_reset = 8'h00;
		endcase
	end
endfunction

function [7:0] slot_mask;
	input [2:0] sel;
	begin
		case (sel)
		SLOT_CHARGE_PUMP: slot_mask = `MASK_CHARGE_PUMP_CONFIG;
		SLOT_BANK_ENABLE: slot_mask = `MASK_BANK_ENABLE;
		SLOT_PATTERN:     slot_mask = `MASK_PATTERN_ENABLE;
		SLOT_ZONE_UPPER:  slot_mask = `MASK_ZONE_SCALER_UPPER;
		SLOT_ZONE_MIDDLE: slot_mask = `MASK_ZONE_SCALER_MIDDLE;
		SLOT_ZONE_ZERO:   slot_mask = `MASK_ZONE_SCALER_ZERO;
		SLOT_BOOST_PWM:   slot_mask = `MASK_BOOST_PWM_CONFIG;
		SLOT_SENSOR:      slot_mask = `MASK_SENSOR_RESISTOR;
		default:          slot_mask = 8'h00;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Address decode; unmapped addresses leave slot_hit low

always @* begin
	slot_index = SLOT_CHARGE_PUMP;
	slot_hit   = 1'b1;
	case (addr_in)
	`ADDR_CHARGE_PUMP_CONFIG: slot_index = SLOT_CHARGE_PUMP;
	`ADDR_BANK_ENABLE:        slot_index = SLOT_BANK_ENABLE;
	`ADDR_PATTERN_ENABLE:     slot_index = SLOT_PATTERN;
	`ADDR_ZONE_SCALER_UPPER:  slot_index = SLOT_ZONE_UPPER;
	`ADDR_ZONE_SCALER_MIDDLE: slot_index = SLOT_ZONE_MIDDLE;
	`ADDR_ZONE_SCALER_ZERO:   slot_index = SLOT_ZONE_ZERO;
	`ADDR_BOOST_PWM_CONFIG:   slot_index = SLOT_BOOST_PWM;
	`ADDR_SENSOR_RESISTOR:    slot_index = SLOT_SENSOR;
	default:                  slot_hit   = 1'b0;
	endcase
end

assign wr_take  = enable_in & wr_strobe_in;
assign rd_take  = enable_in & rd_strobe_in;
assign any_take = wr_take | rd_take;

////////////////////////////////////////////////////////////////////////////////
// Register writes; masks keep unused bits at zero whatever the host sends

always @(posedge clock_in) begin
	if (!resetn_in) begin
		for (k = 0; k < SLOT_COUNT; k = k + 1) begin
			cfg_slot_reg[k] <= slot_reset(k[2:0]);
		end
	end else if (wr_take && slot_hit) begin
		cfg_slot_reg[slot_index] <= wdata_in & slot_mask(slot_index);
	end
end

// Named views of the store for the decoders below
assign charge_pump_config     = cfg_slot_reg[SLOT_CHARGE_PUMP];
assign bank_enable            = cfg_slot_reg[SLOT_BANK_ENABLE];
assign pattern_enable_scaling = cfg_slot_reg[SLOT_PATTERN];
assign zone_scaler_upper      = cfg_slot_reg[SLOT_ZONE_UPPER];
assign zone_scaler_middle     = cfg_slot_reg[SLOT_ZONE_MIDDLE];
assign zone_scaler_zero       = cfg_slot_reg[SLOT_ZONE_ZERO];
assign boost_pwm_config       = cfg_slot_reg[SLOT_BOOST_PWM];
assign sensor_resistor_select = cfg_slot_reg[SLOT_SENSOR];

////////////////////////////////////////////////////////////////////////////////
// Read path; a read and a write in one cycle return the old value

always @* begin
	rdata_next = 8'h00;
	hit_next   = slot_hit;
	if (slot_hit) begin
		rdata_next = cfg_slot_reg[slot_index];
	end
end

always @(posedge clock_in) begin
	if (!resetn_in) begin
		rvalid_out <= 1'b0;
	end else if (enable_in) begin
		rvalid_out <= rd_strobe_in;
	end
end

// Hit reports on writes as well, so a host can spot a bad address
always @(posedge clock_in) begin
	if (!resetn_in) begin
		addr_hit_out <= 1'b0;
	end else if (enable_in) begin
		addr_hit_out <= any_take & hit_next;
	end
end

// Read data holds until the next read
always @(posedge clock_in) begin
	if (!resetn_in) begin
		rdata_out <= 8'h00;
	end else if (rd_take) begin
		rdata_out <= rdata_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Decoded controls, registered so every output comes from a flip-flop

// Auto gain for both 0X codes; bit 1 is a don't-care there
always @* begin
	gain_next = `GAIN_AUTO;
	if (charge_pump_config[`CP_GAIN_HI]) begin
		if (charge_pump_config[`CP_GAIN_LO]) begin
			gain_next = `GAIN_TWO;
		end else begin
			gain_next = `GAIN_ONE;
		end
	end
end

generate
	for (pg = 0; pg < 4; pg = pg + 1) begin : pattern_split
		assign pattern_enable_next[pg]  = pattern_enable_scaling[2*pg];
		assign pattern_scaling_next[pg] = pattern_enable_scaling[2*pg+1];
	end
endgenerate

always @(posedge clock_in) begin
	if (!resetn_in) begin
		pump_disable_out <= 1'b0;
	end else if (enable_in) begin
		pump_disable_out <= charge_pump_config[`CP_DISABLE_BIT];
	end
end

always @(posedge clock_in) begin
	if (!resetn_in) begin
		pump_gain_out <= `GAIN_AUTO;
	end else if (enable_in) begin
		pump_gain_out <= gain_next;
	end
end

always @(posedge clock_in) begin
	if (!resetn_in) begin
		bank_enable_out <= 6'h00;
	end else if (enable_in) begin
		bank_enable_out <= bank_enable[5:0];
	end
end

always @(posedge clock_in) begin
	if (!resetn_in) begin
		pattern_enable_out <= 4'h0;
	end else if (enable_in) begin
		pattern_enable_out <= pattern_enable_next;
	end
end

always @(posedge clock_in) begin
	if (!resetn_in) begin
		pattern_scaling_out <= 4'h0;
	end else if (enable_in) begin
		pattern_scaling_out <= pattern_scaling_next;
	end
end

// Zone n code at bits 4n+3:4n; factor is (code+1)/16, zone 0 resets to 1/16
always @(posedge clock_in) begin
	if (!resetn_in) begin
		zone_scaler_out <= 20'hffff0;
	end else if (enable_in) begin
		zone_scaler_out <= {zone_scaler_upper, zone_scaler_middle,
			zone_scaler_zero[3:0]};
	end
end

always @(posedge clock_in) begin
	if (!resetn_in) begin
		pwm_active_high_out <= 1'b1;
	end else if (enable_in) begin
		pwm_active_high_out <= boost_pwm_config[`BP_POL_BIT];
	end
end

always @(posedge clock_in) begin
	if (!resetn_in) begin
		overvoltage_limit_out <= 2'h0;
	end else if (enable_in) begin
		overvoltage_limit_out <= boost_pwm_config[`BP_OVL_HI:`BP_OVL_LO];
	end
end

always @(posedge clock_in) begin
	if (!resetn_in) begin
		boost_fast_out <= 1'b0;
	end else if (enable_in) begin
		boost_fast_out <= boost_pwm_config[`BP_FREQ_BIT];
	end
end

// Code is current in 10 uA steps at 2 V full scale
always @(posedge clock_in) begin
	if (!resetn_in) begin
		sensor_gain_resistor_out <= 7'h00;
	end else if (enable_in) begin
		sensor_gain_resistor_out <= sensor_resistor_select[6:0];
	end
end

always @(posedge clock_in) begin
	if (!resetn_in) begin
		sensor_input_hiz_out <= 1'b1;
	end else if (enable_in) begin
		sensor_input_hiz_out <= (sensor_resistor_select[6:0] == 7'h00);
	end
end

// Pattern wins over zone targets to avoid conflicting currents
always @(posedge clock_in) begin
	if (!resetn_in) begin
		bank_zone_target_use_out <= 6'h00;
	end else if (enable_in) begin
		bank_zone_target_use_out <= bank_zone_map_in & ~bank_pattern_on_in;
	end
end
endmodule

// ==== verification/host_model.sv ====
// Host side model issuing register accesses
`timescale 1ns/1ns
module host_model (
	input  wire logic       clock_in,
	input  wire logic [7:0] rdata_in,
	output logic            wr_out = 1'b0,
	output logic            rd_out = 1'b0,
	output logic [7:0]      addr_out = 8'h00,
	output logic [7:0]      wdata_out = 8'h00
);
	task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge clock_in) #1;
		addr_out = a;
		wdata_out = d;
		wr_out = w;
		rd_out = !w;
		@(posedge clock_in) #1;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = ~d;
	endtask
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		put(a, 8'h00, 1'b0);
		d = rdata_in;
	endtask
endmodule

// ==== verification/light_cfg_monitor.sv ====
// Port timing checks for the lighting configuration bank
`timescale 1ns/1ns
module light_cfg_monitor (
	input wire logic       clock_in, resetn_in, enable_in, wr_strobe_in, rd_strobe_in,
	input wire logic [7:0] addr_in, wdata_in, rdata_out,
	input wire logic [5:0] bank_pattern_on_in, bank_zone_map_in, bank_zone_target_use_out,
	input wire logic       rvalid_out, addr_hit_out, sensor_input_hiz_out,
	input wire logic [1:0] pump_gain_out,
	input wire logic [6:0] sensor_gain_resistor_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	AST_RD_VALID:
		assert property (enable_in && rd_strobe_in |=> rvalid_out) else $error("no rvalid");
	AST_RD_PULSE:
		assert property (enable_in && !rd_strobe_in |=> !rvalid_out) else $error("stray rvalid");
	AST_RDATA_HOLD:
		assert property (enable_in && !rd_strobe_in |=> $stable(rdata_out)) else $error("rdata moved");
	AST_UNMAPPED:
		assert property (enable_in && rd_strobe_in && addr_in == 8'h31 |=> !addr_hit_out)
			else $error("hit on unmapped");
	AST_MAPPED:
		assert property (enable_in && rd_strobe_in && addr_in == 8'h2c |=> addr_hit_out)
			else $error("miss on mapped");
	AST_BANK_UNUSED:
		assert property (enable_in && rd_strobe_in && addr_in == 8'h27 |=> rdata_out[7:6] == 2'h0)
			else $error("unused bank bits set");
	AST_GAIN_TWO:
		assert property (enable_in && wr_strobe_in && addr_in == 8'h26 && wdata_in[2:1] == 2'h3
			|-> ##2 pump_gain_out == 2'h2) else $error("gain not 2x");
	AST_HIZ:
		assert property (sensor_input_hiz_out == (sensor_gain_resistor_out == 7'h00))
			else $error("hiz mismatch");
	AST_TARGET:
		assert property (enable_in |=> bank_zone_target_use_out ==
			($past(bank_zone_map_in) & ~$past(bank_pattern_on_in))) else $error("target use");
endmodule
bind lighting_power_config_regs light_cfg_monitor mon (
	.clock_in(clock_in), .resetn_in(resetn_in), .enable_in(enable_in),
	.wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .rdata_out(rdata_out), .bank_pattern_on_in(bank_pattern_on_in),
	.bank_zone_map_in(bank_zone_map_in), .bank_zone_target_use_out(bank_zone_target_use_out),
	.rvalid_out(rvalid_out), .addr_hit_out(addr_hit_out),
	.sensor_input_hiz_out(sensor_input_hiz_out), .pump_gain_out(pump_gain_out),
	.sensor_gain_resistor_out(sensor_gain_resistor_out));

// ==== verification/tb_lighting_power_config_regs.sv ====
// Self-checking bench for the lighting configuration bank
`timescale 1ns/1ns
module tb_lighting_power_config_regs;
	logic clock_in, resetn_in, enable_in, wr, rd, rv, hit, pdis, pwm, fast, hiz;
	logic [7:0] addr, wdata, rdata, d;
	logic [5:0] pat, zmap, ben, tuse;
	logic [1:0] gain, ovl;
	logic [3:0] pen, psc;
	logic [19:0] zsc;
	logic [6:0] rsel;
	int failures, compares;
	logic [7:0] adr [8] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h30};
	logic [7:0] rst [8] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00};
	logic [7:0] msk [8] = '{8'h07, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h0f, 8'h7f};
	host_model host (.clock_in(clock_in), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
		.addr_out(addr), .wdata_out(wdata));
	lighting_power_config_regs DUT (.clock_in(clock_in), .resetn_in(resetn_in),
		.enable_in(enable_in), .wr_strobe_in(wr), .rd_strobe_in(rd), .addr_in(addr),
		.wdata_in(wdata), .bank_pattern_on_in(pat), .bank_zone_map_in(zmap),
		.rdata_out(rdata), .rvalid_out(rv), .addr_hit_out(hit), .pump_disable_out(pdis),
		.pump_gain_out(gain), .bank_enable_out(ben), .pattern_enable_out(pen),
		.pattern_scaling_out(psc), .zone_scaler_out(zsc), .pwm_active_high_out(pwm),
		.overvoltage_limit_out(ovl), .boost_fast_out(fast), .sensor_gain_resistor_out(rsel),
		.sensor_input_hiz_out(hiz), .bank_zone_target_use_out(tuse));
	task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic complete_run();
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	// Whole sequence needs about 80 cycles
	initial begin
		#100000;
		failures++;
		complete_run();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		resetn_in = 1'b0;
		enable_in = 1'b1;
		pat = 6'h00;
		zmap = 6'h00;
		repeat (8) @(posedge clock_in);
		#1 resetn_in = 1'b1;
		chk("pwm", 20'h1, pwm);
		chk("zsc", 20'hffff0, zsc);
		chk("hiz", 20'h1, hiz);
		for (int i = 0; i < 8; i++) begin
			host.get(adr[i], d);
			chk("rst", rst[i], d);
			chk("hit", 20'h1, hit);
			chk("rvalid", 20'h1, rv);
			host.put(adr[i], 8'hff, 1'b1);
			host.get(adr[i], d);
			chk("mask", msk[i], d);
		end
		chk("pdis", 20'h1, pdis);
		chk("gain", 20'h2, gain);
		chk("ovl", 20'h3, ovl);
		chk("fast", 20'h1, fast);
		chk("rsel", 20'h7f, rsel);
		chk("ben", 20'h3f, ben);
		chk("pen", 20'hf, pen);
		chk("psc", 20'hf, psc);
		chk("zsc", 20'hfffff, zsc);
		for (int g = 0; g < 4; g++) begin
			host.put(8'h26, 8'(g * 2), 1'b1);
			@(posedge clock_in) #1;
			chk("gain", (g < 2) ? 20'h0 : 20'(g - 1), gain);
		end
		host.put(8'h2c, 8'h02, 1'b1);
		@(posedge clock_in) #1;
		chk("ovl", 20'h1, {pwm, fast, ovl});
		host.put(8'h31, 8'h5a, 1'b1);
		host.get(8'h31, d);
		chk("unmapped", 20'h0, d);
		chk("hit", 20'h0, hit);
		enable_in = 1'b0;
		host.put(8'h27, 8'h00, 1'b1);
		enable_in = 1'b1;
		host.get(8'h27, d);
		chk("frozen", 20'h3f, d);
		pat = 6'h0f;
		zmap = 6'h3c;
		repeat (2) @(posedge clock_in);
		#1 chk("tuse", 20'h30, tuse);
		complete_run();
	end
endmodule
